// ===== rtl/bus_hold_defines.svh
/*
  Shared constants for the bus hold, backoff and snoop controller ends.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef BUS_HOLD_DEFINES_SVH
`define BUS_HOLD_DEFINES_SVH

`define BH_ADDR_W      32
`define BH_DATA_W      16
`define BH_OFFSET_BITS 4
`define BH_INDEX_BITS  3
`define BH_LINE_BEATS  8
`define BH_BEAT_W      4
`define BH_SYNC_IDLE   3'h7

`endif

// ===== rtl/bus_hold_pkg.sv
/*
  Types shared by both ends of the processor bus.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bus_hold_pkg;

  // Gray coded along idle, address, data, hold, backoff.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_DATA = 3'h3,
    ST_HOLD = 3'h2,
    ST_BUS_ABORT_REQUEST_N = 3'h6
  } bus_state_e;

  // Gray coded along idle, wait, beat.
  typedef enum logic [1:0] {
    RS_IDLE = 2'h0,
    RS_WAIT = 2'h1,
    RS_BEAT = 2'h3
  } resp_state_e;

endpackage : bus_hold_pkg

// ===== rtl/bus_hold_if.sv
/*
  Processor bus pins between the processor end and the external master end.
  Assumes both ends run on one clock; the shared address wire is resolved
  here from the two output enables.
*/
`timescale 1ns/1ps
`include "bus_hold_defines.svh"

interface bus_hold_if #(
  parameter int ADDR_W = `BH_ADDR_W,
  parameter int DATA_W = `BH_DATA_W
);
  logic              hold_request;
  logic              hold_grant;
  logic              bus_abort_request_n;
  logic              addr_float_request;
  logic              snoop_addr_strobe_n;
  logic              line_fill_permit_n;
  logic              ready_n;
  logic              burst_ready_n;
  logic              flush_n;
  logic [ADDR_W-1:0] cpu_addr;
  logic              cpu_addr_oe;
  logic [ADDR_W-1:0] ext_addr;
  logic              ext_addr_oe;
  logic [ADDR_W-1:0] addr;
  logic              cycle_start_n;
  logic              cycle_write;
  logic              cycle_cacheable;
  logic              ctl_oe;
  logic [DATA_W-1:0] read_data;

  assign addr = cpu_addr_oe ? cpu_addr : (ext_addr_oe ? ext_addr : '0);

  modport cpu (
    input  hold_request, bus_abort_request_n, addr_float_request,
           snoop_addr_strobe_n, line_fill_permit_n, ready_n, burst_ready_n,
           flush_n, addr, read_data,
    output hold_grant, cpu_addr, cpu_addr_oe, cycle_start_n, cycle_write,
           cycle_cacheable, ctl_oe
  );

  modport master (
    output hold_request, bus_abort_request_n, addr_float_request,
           snoop_addr_strobe_n, line_fill_permit_n, ready_n, burst_ready_n,
           flush_n, ext_addr, ext_addr_oe, read_data,
    input  hold_grant, addr, cycle_start_n, cycle_write, cycle_cacheable,
           ctl_oe
  );
endinterface : bus_hold_if

// ===== rtl/cpu_bus_end.sv
/*
  Processor end: bus cycles, hold, backoff, address float, snoop
  invalidation, line fills and flush over a small tag store.
  Assumes the external master shares the clock; only flush is asynchronous.
*/
// Functional notes
// R1 - Hold grant rises as bus floats
// R2 - Grant held through hold, dropped after
// R3 - Backoff floats hold pins next clock
// R4 - No hold grant for backoff float
// R5 - Backoff beats ready in same clock
// R6 - Stay floated until backoff negated
// R7 - Interrupted cycle restarts after backoff
// R8 - Address float request floats address next
// R9 - Only address floats under address float
// R10 - Snoop strobe with valid address invalidates
// R11 - Permit before first ready makes fill
// R12 - Permit before last ready installs line
// R13 - One clock flush clears whole cache
// R14 - Hold waits for cycle or lock end
// R15 - Flush synchronised, acted on once
`timescale 1ns/1ps
`include "bus_hold_defines.svh"

module cpu_bus_end #(
  parameter int ADDR_W     = `BH_ADDR_W,
  parameter int DATA_W     = `BH_DATA_W,
  parameter int OFF_BITS   = `BH_OFFSET_BITS,
  parameter int IDX_BITS   = `BH_INDEX_BITS,
  parameter int LINE_BEATS = `BH_LINE_BEATS
) (
  input  wire logic              clock,
  input  wire logic              rst,
  bus_hold_if.cpu                bus,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic              req_write,
  input  wire logic              req_cacheable,
  input  wire logic              req_lock,
  output logic                   done,
  output logic [DATA_W-1:0]      done_data,
  output logic                   done_filled,
  output logic                   flush_done
);

  localparam int LINES = 1 << IDX_BITS;
  localparam int TAG_W = ADDR_W - OFF_BITS - IDX_BITS;

  typedef struct packed {
    bus_hold_pkg::bus_state_e        state;
    logic [ADDR_W-1:0]               addr;
    logic                            write;
    logic                            cacheable;
    logic                            lock;
    logic                            fill;
    logic [`BH_BEAT_W-1:0]           beat;
    logic                            restart;
    logic                            permit_prev;
    logic                            af;
    logic [2:0]                      flush_sync;
    logic                            flush_armed;
    logic                            done;
    logic                            filled;
    logic                            flushed;
    logic [DATA_W-1:0]               rdata;
    logic [LINES-1:0]                valid;
    logic [LINES-1:0][TAG_W-1:0]     tags;
  } core_s;

  core_s core_reg;
  core_s core_next;

  function automatic logic [IDX_BITS-1:0] line_index(
    input logic [ADDR_W-1:0] a
  );
    line_index = a[OFF_BITS +: IDX_BITS];
  endfunction : line_index

  function automatic logic [TAG_W-1:0] line_tag(input logic [ADDR_W-1:0] a);
    line_tag = a[ADDR_W-1 -: TAG_W];
  endfunction : line_tag

  logic driving;
  logic any_ready;
  logic last_beat;
  logic fill_now;
  logic flush_seen;

  assign any_ready = !bus.ready_n || !bus.burst_ready_n;
  // R11 fill chosen by permit sampled one clock before first ready.
  assign fill_now  = core_reg.fill ||
                     (core_reg.beat == '0 && core_reg.cacheable &&
                      !core_reg.write && !core_reg.permit_prev);
  assign last_beat = !fill_now ||
                     (core_reg.beat ==
                      `BH_BEAT_W'(LINE_BEATS - 1));
  // R15 act on the second stage so a one clock low is still caught.
  // Rearming waits until the second and third stages agree high again.
  assign flush_seen = core_reg.flush_armed && !core_reg.flush_sync[1];

  // R14 new cycles continue a lock even while hold is requested.
  assign req_ready = core_reg.state == bus_hold_pkg::ST_IDLE &&
                     bus.bus_abort_request_n &&
                     (!bus.hold_request || core_reg.lock);

  always_comb begin
    core_next = core_reg;
    core_next.done = 1'b0;
    core_next.flushed = 1'b0;
    core_next.permit_prev = bus.line_fill_permit_n;
    // R8 address float follows the request by one clock.
    core_next.af = bus.addr_float_request;
    core_next.flush_sync = {core_reg.flush_sync[1:0], bus.flush_n};
    if (core_reg.flush_sync[1] && core_reg.flush_sync[2]) begin
      core_next.flush_armed = 1'b1;
    end

    case (core_reg.state)
      bus_hold_pkg::ST_IDLE: begin
        // R14 hold granted only outside a cycle and a lock.
        if (bus.hold_request && !core_reg.lock) begin
          core_next.state = bus_hold_pkg::ST_HOLD;
        end else if (!bus.bus_abort_request_n) begin
          core_next.state = bus_hold_pkg::ST_BUS_ABORT_REQUEST_N;
        end else if (req_valid && req_ready) begin
          core_next.state = bus_hold_pkg::ST_ADDR;
          core_next.addr = req_addr;
          core_next.write = req_write;
          core_next.cacheable = req_cacheable;
          core_next.lock = req_lock;
        end
      end
      bus_hold_pkg::ST_ADDR: begin
        if (!bus.bus_abort_request_n) begin
          core_next.state = bus_hold_pkg::ST_BUS_ABORT_REQUEST_N;
          core_next.restart = 1'b1;
        end else begin
          core_next.state = bus_hold_pkg::ST_DATA;
          core_next.fill = 1'b0;
          core_next.beat = '0;
        end
      end
      bus_hold_pkg::ST_DATA: begin
        // R5 backoff takes precedence over a ready in the same clock.
        if (!bus.bus_abort_request_n) begin
          // R3 float begins in the next clock.
          core_next.state = bus_hold_pkg::ST_BUS_ABORT_REQUEST_N;
          core_next.restart = 1'b1;
        end else if (any_ready) begin
          core_next.rdata = bus.read_data;
          core_next.fill = fill_now;
          core_next.beat = core_reg.beat + `BH_BEAT_W'(1);
          if (last_beat) begin
            core_next.state = bus_hold_pkg::ST_IDLE;
            core_next.done = 1'b1;
            core_next.filled = fill_now;
            // R12 install only if permit stood before the last ready.
            if (fill_now && !core_reg.permit_prev) begin
              core_next.valid[line_index(core_reg.addr)] = 1'b1;
              core_next.tags[line_index(core_reg.addr)] =
                line_tag(core_reg.addr);
            end
          end
        end
      end
      bus_hold_pkg::ST_HOLD: begin
        // R2 leave hold once the request is withdrawn.
        if (!bus.hold_request) begin
          core_next.state = bus_hold_pkg::ST_IDLE;
        end
      end
      bus_hold_pkg::ST_BUS_ABORT_REQUEST_N: begin
        // R6 floated until backoff negates.
        if (bus.bus_abort_request_n) begin
          // R7 rerun the interrupted cycle from its start.
          core_next.state = core_reg.restart ? bus_hold_pkg::ST_ADDR
                                             : bus_hold_pkg::ST_IDLE;
          core_next.restart = 1'b0;
        end
      end
      default: begin
        core_next.state = bus_hold_pkg::ST_IDLE;
      end
    endcase

    // R10 snoop address invalidates a matching line.
    if (!bus.snoop_addr_strobe_n &&
        core_reg.valid[line_index(bus.addr)] &&
        core_reg.tags[line_index(bus.addr)] == line_tag(bus.addr)) begin
      core_next.valid[line_index(bus.addr)] = 1'b0;
    end

    // R13 one detected flush clears every line.
    if (flush_seen) begin
      core_next.valid = '0;
      core_next.flush_armed = 1'b0;
      core_next.flushed = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_reg <= '0;
      core_reg.state <= bus_hold_pkg::ST_IDLE;
      core_reg.permit_prev <= 1'b1;
      core_reg.flush_sync <= `BH_SYNC_IDLE;
      core_reg.flush_armed <= 1'b1;
    end else begin
      core_reg <= core_next;
    end
  end

  // R3 backoff floats the same pins as hold.
  assign driving = core_reg.state != bus_hold_pkg::ST_HOLD &&
                   core_reg.state != bus_hold_pkg::ST_BUS_ABORT_REQUEST_N;

  // R1 grant and float share one state, so one clock.
  // R4 backoff state never raises the grant.
  assign bus.hold_grant = core_reg.state == bus_hold_pkg::ST_HOLD;
  // R9 address float leaves the control pins driven.
  assign bus.cpu_addr_oe = driving && !core_reg.af;
  assign bus.ctl_oe = driving;
  assign bus.cpu_addr = core_reg.addr;
  assign bus.cycle_start_n = core_reg.state != bus_hold_pkg::ST_ADDR;
  assign bus.cycle_write = core_reg.write;
  assign bus.cycle_cacheable = core_reg.cacheable;

  assign done = core_reg.done;
  assign done_data = core_reg.rdata;
  assign done_filled = core_reg.filled;
  assign flush_done = core_reg.flushed;

endmodule : cpu_bus_end

// ===== rtl/master_bus_end.sv
/*
  External master end: drives hold, backoff, address float, snoops and
  flush from user levels, and answers processor cycles with ready beats.
  Assumes the processor end shares the clock.
*/
`timescale 1ns/1ps
`include "bus_hold_defines.svh"

module master_bus_end #(
  parameter int ADDR_W     = `BH_ADDR_W,
  parameter int DATA_W     = `BH_DATA_W,
  parameter int LINE_BEATS = `BH_LINE_BEATS
) (
  input  wire logic              clock,
  input  wire logic              rst,
  bus_hold_if.master             bus,
  input  wire logic              user_hold,
  input  wire logic              user_abort,
  input  wire logic              user_addr_float,
  input  wire logic              user_flush,
  input  wire logic              user_cache_ok,
  input  wire logic              snoop_valid,
  output logic                   snoop_ready,
  input  wire logic [ADDR_W-1:0] snoop_addr
);

  typedef struct packed {
    bus_hold_pkg::resp_state_e state;
    logic                      hold;
    logic                      abort;
    logic                      af;
    logic                      af_old;
    logic                      flush;
    logic                      snoop;
    logic [ADDR_W-1:0]         snoop_addr;
    logic                      permit;
    logic                      fill;
    logic [`BH_BEAT_W-1:0]     left;
    logic [DATA_W-1:0]         data;
  } resp_s;

  resp_s resp_reg;
  resp_s resp_next;

  // R10 address only driven when the processor has let go of it.
  // A grant alone is not enough: the hold must still be requested, or the
  // processor may take the address back while the strobe stands.
  assign snoop_ready = (bus.hold_grant && resp_reg.hold) ||
                       (resp_reg.af && resp_reg.af_old);

  always_comb begin
    resp_next = resp_reg;
    resp_next.hold = user_hold;
    resp_next.abort = user_abort;
    resp_next.af = user_addr_float;
    resp_next.af_old = resp_reg.af;
    // R13 a single clock of flush suffices.
    resp_next.flush = user_flush;
    // R10 strobe and address move together.
    resp_next.snoop = snoop_valid && snoop_ready;
    resp_next.snoop_addr = snoop_addr;
    case (resp_reg.state)
      bus_hold_pkg::RS_IDLE: begin
        if (!bus.cycle_start_n && bus.ctl_oe && !resp_reg.abort) begin
          // R11 permit stands the clock before the first ready.
          resp_next.fill = bus.cycle_cacheable && !bus.cycle_write &&
                           user_cache_ok;
          resp_next.permit = resp_next.fill;
          resp_next.state = bus_hold_pkg::RS_WAIT;
        end
      end
      bus_hold_pkg::RS_WAIT: begin
        resp_next.state = bus_hold_pkg::RS_BEAT;
        resp_next.left = resp_reg.fill ? `BH_BEAT_W'(LINE_BEATS - 1) : '0;
        resp_next.data = resp_reg.data + DATA_W'(1);
      end
      bus_hold_pkg::RS_BEAT: begin
        resp_next.data = resp_reg.data + DATA_W'(1);
        resp_next.left = resp_reg.left - `BH_BEAT_W'(1);
        if (resp_reg.left == '0) begin
          resp_next.state = bus_hold_pkg::RS_IDLE;
          resp_next.permit = 1'b0;
        end
      end
      default: begin
        resp_next.state = bus_hold_pkg::RS_IDLE;
      end
    endcase
    // R7 an aborted cycle is dropped; the processor reissues it.
    if (resp_reg.abort) begin
      resp_next.state = bus_hold_pkg::RS_IDLE;
      resp_next.permit = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resp_reg <= '0;
      resp_reg.state <= bus_hold_pkg::RS_IDLE;
    end else begin
      resp_reg <= resp_next;
    end
  end

  assign bus.hold_request = resp_reg.hold;
  assign bus.bus_abort_request_n = !resp_reg.abort;
  assign bus.addr_float_request = resp_reg.af;
  assign bus.flush_n = !resp_reg.flush;
  assign bus.snoop_addr_strobe_n = !resp_reg.snoop;
  assign bus.ext_addr_oe = resp_reg.snoop;
  assign bus.ext_addr = resp_reg.snoop_addr;
  assign bus.line_fill_permit_n = !resp_reg.permit;
  // R12 permit is held low through every beat of a fill.
  assign bus.burst_ready_n = !(resp_reg.state == bus_hold_pkg::RS_BEAT &&
                               resp_reg.fill);
  assign bus.ready_n = !(resp_reg.state == bus_hold_pkg::RS_BEAT &&
                         !resp_reg.fill);
  assign bus.read_data = resp_reg.data;

endmodule : master_bus_end

// ===== sim/bus_hold_checker.sv
/*
  Concurrent checks on the pins that join the processor and master ends.
  Assumes one clock, an active high asynchronous reset, and that it is
  instantiated beside the interface with its signals wired by name.
*/
`timescale 1ns/1ps

module bus_hold_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic hold_request,
  input wire logic hold_grant,
  input wire logic bus_abort_request_n,
  input wire logic addr_float_request,
  input wire logic snoop_addr_strobe_n,
  input wire logic ready_n,
  input wire logic burst_ready_n,
  input wire logic cpu_addr_oe,
  input wire logic ext_addr_oe,
  input wire logic cycle_start_n,
  input wire logic ctl_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_grant_float: assert property ($rose(hold_grant) |->
    $fell(ctl_oe) && !cpu_addr_oe) else $error("grant rose apart from float");
  a_grant_stays: assert property (hold_grant && hold_request |=>
    hold_grant) else $error("grant dropped during hold");
  a_grant_drops: assert property (hold_grant && !hold_request |=>
    !hold_grant) else $error("grant kept after hold ended");
  a_abort_float: assert property (!bus_abort_request_n && !hold_grant &&
    !hold_request |=> !ctl_oe && !cpu_addr_oe) else $error("no abort float");
  a_abort_no_grant: assert property (!bus_abort_request_n &&
    !hold_grant && !hold_request |=> !hold_grant)
    else $error("grant raised by abort");
  a_abort_over_ready: assert property (!bus_abort_request_n &&
    !hold_grant && (!ready_n || !burst_ready_n) |=> !ctl_oe)
    else $error("ready won over abort");
  a_abort_stays: assert property (!ctl_oe && !hold_grant &&
    !bus_abort_request_n |=> !ctl_oe && !hold_grant)
    else $error("abort float left early");
  a_addr_float: assert property (addr_float_request |=>
    !cpu_addr_oe) else $error("address still driven");
  a_ctl_kept: assert property (addr_float_request && ctl_oe &&
    bus_abort_request_n && !hold_request && !hold_grant |=> ctl_oe)
    else $error("control floated by address float");
  a_snoop_addr: assert property (!snoop_addr_strobe_n |->
    ext_addr_oe && !cpu_addr_oe) else $error("snoop without address");
  a_hold_waits: assert property (!cycle_start_n |=>
    !hold_grant [*2]) else $error("hold granted inside a cycle");
endmodule : bus_hold_checker

// ===== sim/bus_hold_backoff_snoop_ctrl_tb.sv
/*
  Self-checking bench joining the processor end to the master end.
  Assumes the design files and the defines header are compiled first.
*/
`timescale 1ns/1ps
`include "bus_hold_defines.svh"

module bus_hold_backoff_snoop_ctrl_tb;
  logic                  clock;
  logic                  rst;
  logic                  req_valid;
  logic                  req_ready;
  logic [`BH_ADDR_W-1:0] req_addr;
  logic                  req_write;
  logic                  req_cacheable;
  logic                  req_lock;
  logic                  done;
  logic [`BH_DATA_W-1:0] done_data;
  logic                  done_filled;
  logic                  flush_done;
  logic                  user_hold;
  logic                  user_abort;
  logic                  user_addr_float;
  logic                  user_flush;
  logic                  user_cache_ok;
  logic                  snoop_valid;
  logic                  snoop_ready;
  logic [`BH_ADDR_W-1:0] snoop_addr;
  logic [`BH_DATA_W-1:0] beat_data;
  logic [4:0]            rows [5] = '{5'h02, 5'h0B, 5'h08, 5'h1A, 5'h04};
  int                    fail_count = 0;
  int                    tests_run = 0;
  int                    starts = 0;
  int                    strobes = 0;
  int                    flushes = 0;
  int                    dones = 0;
  int                    n;
  int                    s0;

  bus_hold_if i_bus_hold_if ();
  cpu_bus_end i_cpu_bus_end (.clock(clock), .rst(rst), .bus(i_bus_hold_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
    .req_write(req_write), .req_cacheable(req_cacheable),
    .req_lock(req_lock), .done(done), .done_data(done_data),
    .done_filled(done_filled), .flush_done(flush_done));
  master_bus_end i_master_bus_end (.clock(clock), .rst(rst),
    .bus(i_bus_hold_if), .user_hold(user_hold), .user_abort(user_abort),
    .user_addr_float(user_addr_float), .user_flush(user_flush),
    .user_cache_ok(user_cache_ok), .snoop_valid(snoop_valid),
    .snoop_ready(snoop_ready), .snoop_addr(snoop_addr));
  bus_hold_checker i_bus_hold_checker (.clock(clock), .rst(rst),
    .hold_request(i_bus_hold_if.hold_request),
    .hold_grant(i_bus_hold_if.hold_grant),
    .bus_abort_request_n(i_bus_hold_if.bus_abort_request_n),
    .addr_float_request(i_bus_hold_if.addr_float_request),
    .snoop_addr_strobe_n(i_bus_hold_if.snoop_addr_strobe_n),
    .ready_n(i_bus_hold_if.ready_n),
    .burst_ready_n(i_bus_hold_if.burst_ready_n),
    .cpu_addr_oe(i_bus_hold_if.cpu_addr_oe),
    .ext_addr_oe(i_bus_hold_if.ext_addr_oe),
    .cycle_start_n(i_bus_hold_if.cycle_start_n),
    .ctl_oe(i_bus_hold_if.ctl_oe));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Pulses are counted at the falling edge, where they have settled.
  always @(negedge clock) begin
    if (i_bus_hold_if.cycle_start_n === 1'b0) starts++;
    if (i_bus_hold_if.snoop_addr_strobe_n === 1'b0) strobes++;
    if (flush_done === 1'b1) flushes++;
    if (done === 1'b1) dones++;
    if (!i_bus_hold_if.ready_n || !i_bus_hold_if.burst_ready_n)
      beat_data <= i_bus_hold_if.read_data;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic issue(input logic [31:0] a, input logic w, c, l);
    int k;
    k = 0;
    req_addr = a;
    req_write = w;
    req_cacheable = c;
    req_lock = l;
    req_valid = 1'b1;
    #1;
    while (req_ready !== 1'b1 && k < 50) begin
      @(negedge clock);
      k++;
      #1;
    end
    if (req_ready !== 1'b1) fail_count++;
    @(negedge clock);
    req_valid = 1'b0;
  endtask : issue

  task automatic wait_done(output int cnt);
    cnt = 1;
    while (done !== 1'b1 && cnt < 60) begin
      @(negedge clock);
      cnt++;
    end
    if (done !== 1'b1) fail_count++;
  endtask : wait_done

  task automatic snoop(input logic [31:0] a);
    int k;
    k = 0;
    snoop_addr = a;
    snoop_valid = 1'b1;
    #1;
    while (snoop_ready !== 1'b1 && k < 20) begin
      @(negedge clock);
      k++;
      #1;
    end
    if (snoop_ready !== 1'b1) fail_count++;
    @(negedge clock);
    snoop_valid = 1'b0;
    repeat (3) @(negedge clock);
  endtask : snoop

  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    {req_valid, req_write, req_cacheable, req_lock} = 4'h0;
    {user_hold, user_abort, user_addr_float, user_flush} = 4'h0;
    {user_cache_ok, snoop_valid} = 2'h0;
    req_addr = 32'h0000_0000;
    snoop_addr = 32'h0000_0000;
    repeat (4) @(negedge clock);
    check("reset grant", i_bus_hold_if.hold_grant, 1'b0);
    check("reset ctl oe", i_bus_hold_if.ctl_oe, 1'b1);
    check("reset start", i_bus_hold_if.cycle_start_n, 1'b1);
    rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      user_cache_ok = rows[i][1];
      issue(32'h0000_0100 + 32'(i) * 32'h0000_0010, rows[i][4], rows[i][3],
            rows[i][2]);
      wait_done(n);
      check("fill", done_filled, rows[i][0]);
      check("latency", n, rows[i][0] ? 3 + `BH_LINE_BEATS : 4);
      check("last beat data", done_data, beat_data);
      @(negedge clock);
    end
    check("lines", i_cpu_bus_end.core_reg.valid, 8'h02);
    user_hold = 1'b1;
    repeat (4) @(negedge clock);
    check("grant locked", i_bus_hold_if.hold_grant, 1'b0);
    issue(32'h0000_0200, 1'b0, 1'b0, 1'b0);
    wait_done(n);
    check("locked latency", n, 4);
    repeat (3) @(negedge clock);
    check("grant", i_bus_hold_if.hold_grant, 1'b1);
    check("addr oe hold", i_bus_hold_if.cpu_addr_oe, 1'b0);
    check("refused", req_ready, 1'b0);
    s0 = strobes;
    snoop(32'h0000_0110);
    check("snoops", strobes - s0, 1);
    check("snooped line", i_cpu_bus_end.core_reg.valid, 8'h00);
    user_hold = 1'b0;
    repeat (3) @(negedge clock);
    check("grant off", i_bus_hold_if.hold_grant, 1'b0);
    s0 = starts;
    n = dones;
    issue(32'h0000_0300, 1'b0, 1'b0, 1'b0);
    @(negedge clock);
    user_abort = 1'b1;
    repeat (6) @(negedge clock);
    check("done in abort", dones - n, 0);
    check("abort grant", i_bus_hold_if.hold_grant, 1'b0);
    check("abort float", i_bus_hold_if.ctl_oe, 1'b0);
    user_abort = 1'b0;
    wait_done(n);
    check("restarts", starts - s0, 2);
    s0 = starts;
    user_abort = 1'b1;
    repeat (3) @(negedge clock);
    user_abort = 1'b0;
    repeat (6) @(negedge clock);
    check("idle abort", starts - s0, 0);
    user_addr_float = 1'b1;
    repeat (3) @(negedge clock);
    check("ctl kept", i_bus_hold_if.ctl_oe, 1'b1);
    check("addr float", i_bus_hold_if.cpu_addr_oe, 1'b0);
    s0 = strobes;
    snoop(32'h0000_0120);
    check("float snoop", strobes - s0, 1);
    user_addr_float = 1'b0;
    repeat (3) @(negedge clock);
    check("addr back", i_bus_hold_if.cpu_addr_oe, 1'b1);
    user_cache_ok = 1'b1;
    issue(32'h0000_0130, 1'b0, 1'b1, 1'b0);
    wait_done(n);
    check("refill", i_cpu_bus_end.core_reg.valid, 8'h08);
    @(negedge clock);
    s0 = flushes;
    user_flush = 1'b1;
    @(negedge clock);
    user_flush = 1'b0;
    repeat (8) @(negedge clock);
    check("short flush", flushes - s0, 1);
    check("flushed lines", i_cpu_bus_end.core_reg.valid, 8'h00);
    user_flush = 1'b1;
    repeat (12) @(negedge clock);
    user_flush = 1'b0;
    repeat (8) @(negedge clock);
    check("long flush", flushes - s0, 2);
    // A reset in mid hold must drop the grant and hand the bus back.
    user_hold = 1'b1;
    repeat (3) @(negedge clock);
    check("grant pre reset", i_bus_hold_if.hold_grant, 1'b1);
    rst = 1'b1;
    user_hold = 1'b0;
    @(negedge clock);
    check("mid reset grant", i_bus_hold_if.hold_grant, 1'b0);
    check("mid reset ctl oe", i_bus_hold_if.ctl_oe, 1'b1);
    repeat (3) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    issue(32'h0000_0400, 1'b0, 1'b0, 1'b0);
    wait_done(n);
    check("latency after reset", n, 4);
    close_out();
  end
endmodule : bus_hold_backoff_snoop_ctrl_tb
